// *** inc/rpc_pkg.sv ***
// constants for the receive error performance counters
package rpc_pkg;
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 8;
	localparam int          CNT_W          = 16;
	localparam int          NUM_CH         = 2;
	localparam int          OFS_W          = 12;
	localparam int          CH_W           = 4;
	// per-channel offsets, channel number in address bits 15..12
	localparam logic [11:0] OFS_LCV_HIGH   = 12'h900;
	localparam logic [11:0] OFS_LCV_LOW    = 12'h901;
	localparam logic [11:0] OFS_FAE_HIGH   = 12'h902;
	localparam logic [11:0] OFS_FAE_LOW    = 12'h903;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h910;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h911;
	// status and mask field positions
	localparam int          ST_LCV_EVENT   = 0;
	localparam int          ST_FAE_EVENT   = 1;
	localparam int          ST_LCV_SAT     = 2;
	localparam int          ST_FAE_SAT     = 3;
	localparam logic [7:0]  ST_USED_BITS   = 8'h0F;
	// reset values and counter saturation limit
	localparam logic [15:0] CNT_RESET      = 16'h0000;
	localparam logic [15:0] CNT_MAX        = 16'hFFFF;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;
	localparam logic [7:0]  MASK_RESET     = 8'h00;
	localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
endpackage

// *** rtl/rpc_counter.sv ***
// one 16-bit clear-on-read error counter with low-byte holding register
`timescale 1ns/1ps
`default_nettype none
module rpc_counter
	import rpc_pkg::*;
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// error event and clearing reads
	input  wire logic               event_i,
	input  wire logic               rd_high_i,
	input  wire logic               rd_low_i,
	// state
	output logic [rpc_pkg::CNT_W-1:0]  count_o,
	output logic [rpc_pkg::DATA_W-1:0] low_o,
	output logic                    sat_o
);
	logic [CNT_W-1:0]  count_r;
	logic [CNT_W-1:0]  base;
	logic [DATA_W-1:0] hold_r;
	logic              hold_valid_r;

	always_comb
	begin
		base = count_r;
		if (rd_high_i)
			base = CNT_RESET; // see RL5 see RL11
		else if (rd_low_i && !hold_valid_r)
			base = {count_r[CNT_W-1:DATA_W], BYTE_RESET}; // see RL5
	end

	// counting restarts from the cleared base, then saturates
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			count_r <= CNT_RESET;
		else if (event_i && base != CNT_MAX)
			count_r <= base + 16'h0001; // see RL1 see RL2 see RL12
		else
			count_r <= base;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hold_r       <= BYTE_RESET;
			hold_valid_r <= 1'b0;
		end
		else if (rd_high_i)
		begin
			hold_r       <= count_r[DATA_W-1:0]; // see RL11 see RL6
			hold_valid_r <= 1'b1;
		end
		else if (rd_low_i)
		begin
			hold_r       <= BYTE_RESET;
			hold_valid_r <= 1'b0; // see RL7
		end
	end

	assign count_o = count_r;
	assign low_o   = hold_valid_r ? hold_r : count_r[DATA_W-1:0]; // see RL4
	assign sat_o   = event_i && (base == CNT_MAX);
endmodule // rpc_counter
`default_nettype wire

// *** rtl/rpc_top.sv ***
// receive error performance counters with register port and interrupt
//
// Contract
// RL1 - count line code violations, 16 bits
// RL2 - count frame alignment errors, 16 bits
// RL3 - upper byte shows counter bits 15..8
// RL4 - lower byte shows counter bits 7..0
// RL5 - reading a counter byte clears it
// RL6 - software reads upper byte before lower
// RL7 - software clears by upper then lower read
// RL8 - line code lower byte at 0xn901
// RL9 - alignment upper byte at 0xn902
// RL10 - alignment lower byte at 0xn903
// RL11 - upper read holds low, clears counter
// RL12 - saturate; same-cycle events count after clear
`timescale 1ns/1ps
`default_nettype none
module rpc_top
	import rpc_pkg::*;
(
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// register port
	input  wire logic [rpc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [rpc_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [rpc_pkg::DATA_W-1:0] rdata_o,
	// framer error detectors, one bit per channel
	input  wire logic [rpc_pkg::NUM_CH-1:0] lcv_event_i,
	input  wire logic [rpc_pkg::NUM_CH-1:0] fae_event_i,
	// interrupt
	output logic                            irq_o
);
	logic [CH_W-1:0]               ch_sel;
	logic [OFS_W-1:0]              ofs;
	logic [NUM_CH-1:0]             ch_hit;
	logic [NUM_CH-1:0]             lcv_rd_high;
	logic [NUM_CH-1:0]             lcv_rd_low;
	logic [NUM_CH-1:0]             fae_rd_high;
	logic [NUM_CH-1:0]             fae_rd_low;
	logic [NUM_CH-1:0]             status_rd;
	logic [NUM_CH-1:0]             mask_wr;
	logic [NUM_CH-1:0]             lcv_sat;
	logic [NUM_CH-1:0]             fae_sat;
	logic [NUM_CH-1:0][CNT_W-1:0]  lcv_count;
	logic [NUM_CH-1:0][CNT_W-1:0]  fae_count;
	logic [NUM_CH-1:0][DATA_W-1:0] lcv_low;
	logic [NUM_CH-1:0][DATA_W-1:0] fae_low;
	logic [NUM_CH-1:0][DATA_W-1:0] status_set;
	logic [NUM_CH-1:0][DATA_W-1:0] status_r;
	logic [NUM_CH-1:0][DATA_W-1:0] status_nxt;
	logic [NUM_CH-1:0][DATA_W-1:0] mask_r;
	logic [NUM_CH-1:0][DATA_W-1:0] mask_nxt;
	logic [DATA_W-1:0]             rdata_nxt;
	logic [DATA_W-1:0]             rdata_r;
	logic                          irq_nxt;
	logic                          irq_r;

	assign ch_sel = addr_i[ADDR_W-1:ADDR_W-CH_W];
	assign ofs    = addr_i[OFS_W-1:0];

	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_ch
		assign ch_hit[ch]      = (ch_sel == CH_W'(ch));
		assign lcv_rd_high[ch] = rd_i && ch_hit[ch] && (ofs == OFS_LCV_HIGH);
		assign lcv_rd_low[ch]  = rd_i && ch_hit[ch] && (ofs == OFS_LCV_LOW); // see RL8
		assign fae_rd_high[ch] = rd_i && ch_hit[ch] && (ofs == OFS_FAE_HIGH); // see RL9
		assign fae_rd_low[ch]  = rd_i && ch_hit[ch] && (ofs == OFS_FAE_LOW); // see RL10
		assign status_rd[ch]   = rd_i && ch_hit[ch] && (ofs == OFS_IRQ_STATUS);
		assign mask_wr[ch]     = wr_i && ch_hit[ch] && (ofs == OFS_IRQ_MASK);

		rpc_counter u_lcv
		(
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.event_i   (lcv_event_i[ch]),
			.rd_high_i (lcv_rd_high[ch]),
			.rd_low_i  (lcv_rd_low[ch]),
			.count_o   (lcv_count[ch]),
			.low_o     (lcv_low[ch]),
			.sat_o     (lcv_sat[ch])
		);

		rpc_counter u_fae
		(
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.event_i   (fae_event_i[ch]),
			.rd_high_i (fae_rd_high[ch]),
			.rd_low_i  (fae_rd_low[ch]),
			.count_o   (fae_count[ch]),
			.low_o     (fae_low[ch]),
			.sat_o     (fae_sat[ch])
		);

		always_comb
		begin
			status_set[ch]               = STATUS_RESET;
			status_set[ch][ST_LCV_EVENT] = lcv_event_i[ch];
			status_set[ch][ST_FAE_EVENT] = fae_event_i[ch];
			status_set[ch][ST_LCV_SAT]   = lcv_sat[ch];
			status_set[ch][ST_FAE_SAT]   = fae_sat[ch];
		end

		// new events win over the clearing read
		assign status_nxt[ch] = (status_rd[ch] ? STATUS_RESET : status_r[ch]) | status_set[ch];
		assign mask_nxt[ch]   = mask_wr[ch] ? (wdata_i & ST_USED_BITS) : mask_r[ch];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_r <= {NUM_CH{STATUS_RESET}};
		else
			status_r <= status_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask_r <= {NUM_CH{MASK_RESET}};
		else
			mask_r <= mask_nxt;
	end

	// read mux, samples state before this cycle's clear
	always_comb
	begin
		rdata_nxt = UNMAPPED_DATA;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			if (rd_i && ch_hit[ch])
			begin
				case (ofs)
					OFS_LCV_HIGH   : rdata_nxt = lcv_count[ch][CNT_W-1:DATA_W]; // see RL3
					OFS_LCV_LOW    : rdata_nxt = lcv_low[ch]; // see RL4 see RL8
					OFS_FAE_HIGH   : rdata_nxt = fae_count[ch][CNT_W-1:DATA_W]; // see RL3 see RL9
					OFS_FAE_LOW    : rdata_nxt = fae_low[ch]; // see RL4 see RL10
					OFS_IRQ_STATUS : rdata_nxt = status_r[ch];
					OFS_IRQ_MASK   : rdata_nxt = mask_r[ch];
					default        : rdata_nxt = UNMAPPED_DATA;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= UNMAPPED_DATA;
		else
			rdata_r <= rdata_nxt;
	end

	always_comb
	begin
		irq_nxt = 1'b0;
		for (int ch = 0; ch < NUM_CH; ch++)
			irq_nxt = irq_nxt | (|(status_nxt[ch] & mask_nxt[ch]));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= irq_nxt;
	end

	assign rdata_o = rdata_r;
	assign irq_o   = irq_r;
endmodule // rpc_top
`default_nettype wire

// *** verification/rpc_chk.sv ***
// port checker for the receive error counters
`timescale 1ns/1ps
`default_nettype none
module rpc_chk
	import rpc_pkg::*;
(
	input wire logic                       clk_i,
	input wire logic                       rst_i,
	input wire logic [rpc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [rpc_pkg::DATA_W-1:0] wdata_i,
	input wire logic                       wr_i,
	input wire logic                       rd_i,
	input wire logic [rpc_pkg::DATA_W-1:0] rdata_o,
	input wire logic [rpc_pkg::NUM_CH-1:0] lcv_event_i,
	input wire logic [rpc_pkg::NUM_CH-1:0] fae_event_i,
	input wire logic                       irq_o
);
	logic [7:0] m0_r;
	logic [7:0] m1_r;
	// shadow of the two mask registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (wr_i && addr_i == 16'h0911))
			m0_r <= rst_i ? MASK_RESET : (wdata_i & ST_USED_BITS);
		if (rst_i || (wr_i && addr_i == 16'h1911))
			m1_r <= rst_i ? MASK_RESET : (wdata_i & ST_USED_BITS);
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_IDLE_ZERO: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	AST_UNMAPPED: assert property (rd_i && addr_i[15:12] > 4'h1 |=> rdata_o == 8'h00)
		else $error("unmapped channel read not zero");
	AST_LCV_CLEAR: assert property (rd_i && addr_i == 16'h0900 ##4 rd_i && addr_i == 16'h0900 |=> rdata_o == 8'h00)
		else $error("upper byte not cleared by read");
	AST_FAE_CLEAR: assert property (rd_i && addr_i == 16'h1902 ##4 rd_i && addr_i == 16'h1902 |=> rdata_o == 8'h00)
		else $error("alignment upper byte not cleared");
	AST_STATUS_HIGH: assert property (rd_i && addr_i[11:0] == OFS_IRQ_STATUS |=> rdata_o[7:4] == 4'h0)
		else $error("status upper bits not zero");
	AST_MASK_READ: assert property (rd_i && addr_i == 16'h0911 |=> rdata_o == m0_r)
		else $error("mask readback wrong");
	AST_IRQ_OFF: assert property ((m0_r | m1_r) == 8'h00 |-> !irq_o)
		else $error("interrupt with all masks clear");
	AST_IRQ_LCV: assert property (lcv_event_i[0] && m0_r[ST_LCV_EVENT] && !wr_i |=> irq_o)
		else $error("unmasked violation raised no interrupt");
	AST_IRQ_FAE: assert property (fae_event_i[1] && m1_r[ST_FAE_EVENT] && !wr_i |=> irq_o)
		else $error("unmasked alignment error raised no interrupt");
	COV_UPPER: cover property (rd_i && addr_i == 16'h0900);
	COV_LOWER: cover property (rd_i && addr_i == 16'h1903);
	COV_IRQ: cover property ($rose(irq_o));
endmodule // rpc_chk
`default_nettype wire

// *** verification/rpc_top_tb.sv ***
// self-checking bench for the receive error counters
`timescale 1ns/1ps
`default_nettype none
module rpc_top_tb;
	import rpc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [7:0]  rdata_o;
	logic [1:0]  lcv_event_i = 2'b00;
	logic [1:0]  fae_event_i = 2'b00;
	logic        irq_o;
	int          miscompares = 0;
	int          n_compared = 0;
	rpc_top rpc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .lcv_event_i(lcv_event_i), .fae_event_i(fae_event_i), .irq_o(irq_o));
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end
	task chk(input logic [15:0] a, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			$display("[FAIL] item %h expected %h seen %h", a, e, s);
			miscompares++;
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(a, rdata_o, e);
	endtask
	task ev(input logic [1:0] l, input logic [1:0] f, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			lcv_event_i <= l;
			fae_event_i <= f;
		end
		@(posedge clk_i);
		lcv_event_i <= 2'b00;
		fae_event_i <= 2'b00;
		#1;
	endtask
	task t_reset;
		logic [15:0] ofs [6];
		ofs = '{16'h0900, 16'h0901, 16'h0902, 16'h0903, 16'h0910, 16'h0911};
		foreach (ofs[i]) rd(ofs[i], 8'h00);
		chk(16'hFFFF, irq_o, 8'h00);
		$display("test reset done");
	endtask
	task t_count;
		ev(2'b01, 2'b00, 300);
		rd(16'h0900, 8'h01);
		rd(16'h0901, 8'h2C);
		rd(16'h0900, 8'h00);
		rd(16'h0901, 8'h00);
		ev(2'b00, 2'b10, 258);
		rd(16'h1902, 8'h01);
		rd(16'h1903, 8'h02);
		rd(16'h1902, 8'h00);
		rd(16'h0902, 8'h00);
		ev(2'b01, 2'b00, 3);
		rd(16'h0900, 8'h00);
		ev(2'b01, 2'b00, 2);
		rd(16'h0901, 8'h03);
		rd(16'h0900, 8'h00);
		rd(16'h0901, 8'h02);
		// event in the cycle of a clearing upper read
		@(posedge clk_i);
		lcv_event_i <= 2'b01;
		rd_i <= 1'b1;
		addr_i <= 16'h0900;
		@(posedge clk_i);
		lcv_event_i <= 2'b00;
		rd_i <= 1'b0;
		#1 chk(16'h0900, rdata_o, 8'h00);
		rd(16'h0901, 8'h00);
		rd(16'h0900, 8'h00);
		rd(16'h0901, 8'h01);
		$display("test count done");
	endtask
	task t_sat;
		rd(16'h0910, 8'h01);
		ev(2'b01, 2'b00, 65540);
		rd(16'h0910, 8'h05);
		rd(16'h0900, 8'hFF);
		rd(16'h0901, 8'hFF);
		$display("test saturate done");
	endtask
	task t_irq;
		wr(16'h0911, 8'h01);
		rd(16'h0911, 8'h01);
		ev(2'b01, 2'b00, 1);
		chk(16'hFFFF, irq_o, 8'h01);
		rd(16'h0910, 8'h01);
		chk(16'hFFFF, irq_o, 8'h00);
		rd(16'h1910, 8'h02);
		wr(16'h1911, 8'hFE);
		rd(16'h1911, 8'h0E);
		ev(2'b00, 2'b10, 1);
		chk(16'hFFFF, irq_o, 8'h01);
		wr(16'h0911, 8'h00);
		wr(16'h1911, 8'h00);
		#1 chk(16'hFFFF, irq_o, 8'h00);
		wr(16'h0900, 8'hFF);
		rd(16'h0900, 8'h00);
		rd(16'h2900, 8'h00);
		rd(16'h0905, 8'h00);
		$display("test interrupt done");
	endtask
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_count();
		t_sat();
		t_irq();
		summarize();
	end
endmodule // rpc_top_tb
bind rpc_top rpc_chk rpc_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .lcv_event_i(lcv_event_i), .fae_event_i(fae_event_i), .irq_o(irq_o));
`default_nettype wire
